/* rtl/ebp_pwm.sv */
`timescale 1ns/1ps
// What the document requires of this block and its software
// [RULE1] period is (limit+1)*4*prescale oscillator periods
// [RULE2] at limit match: clear timer, set output, load duty; code does not set the output when the new duty is zero
// [RULE3] postscaler never changes pwm period
// [RULE4] duty is buffer plus control bits 5:4
// [RULE5] duty buffer copied only at period match
// [RULE6] active duty copy read-only to software
// [RULE7] clear output when duty equals extended timer
// [RULE8] duty beyond period never clears output
// [RULE9] two-bit field picks one of four modes
// [RULE10] half-bridge: a is pwm, b complement
// [RULE11] half-bridge delays rising edges by dead band
// [RULE12] dead band over duty keeps output inactive
// [RULE13] full-bridge: a on d pwm, or c on b pwm
// [RULE14] direction change applies from next cycle
// [RULE15] direction swap one prescaled quarter before end; code opens the swap window one timer count (4*prescale clocks) before end
// [RULE16] prescaler divides by 1, 4 or 16
// [RULE17] no dead band in full-bridge modes
// [RULE18] software lowers duty before reversing at high duty
// [RULE19] software enables pin drivers after setup
// [RULE20] controls load at period, dead band earlier
// [RULE21] polarity chosen per a/c and b/d pair
module ebp_pwm
  import ebp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire ebp_bus_t bus,
  output logic [7:0] readData,
  // bridge outputs
  output ebp_out_t pwmOut
);
  // ==========================================
  // registers
  logic [7:0] periodLimit_reg, periodLimit_next;
  logic [7:0] dutyBuffer_reg, dutyBuffer_next;
  logic [7:0] control_reg, control_next;
  logic [6:0] deadBand_reg, deadBand_next;
  logic [1:0] prescSel_reg, prescSel_next;
  logic [7:0] readData_reg, readData_next;
  logic [7:0] timer_reg, timer_next;
  logic [9:0] dutyActive_reg, dutyActive_next;
  always_comb
  begin
    periodLimit_next = periodLimit_reg;
    dutyBuffer_next = dutyBuffer_reg;
    control_next = control_reg;
    deadBand_next = deadBand_reg;
    prescSel_next = prescSel_reg;
    readData_next = 8'h00;
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_PERIOD_LIMIT: periodLimit_next = bus.wdata;
        ADDR_DUTY_BUFFER: dutyBuffer_next = bus.wdata; // RULE5
        ADDR_PWM_CONTROL: control_next = bus.wdata; // RULE14
        ADDR_DEAD_BAND: deadBand_next = bus.wdata[DB_HI:0];
        ADDR_TIMER_CONTROL: prescSel_next = bus.wdata[1:0];
        default: ; // duty copy ignores writes RULE6
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_PERIOD_LIMIT: readData_next = periodLimit_reg;
        ADDR_DUTY_BUFFER: readData_next = dutyBuffer_reg;
        ADDR_DUTY_ACTIVE: readData_next = dutyActive_reg[9:2];
        ADDR_PWM_CONTROL: readData_next = control_reg;
        ADDR_DEAD_BAND: readData_next = {1'b0, deadBand_reg};
        ADDR_TIMER_CONTROL: readData_next = {6'h00, prescSel_reg};
        ADDR_TIMER_VALUE: readData_next = timer_reg;
        default: readData_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      periodLimit_reg <= 8'hff;
      dutyBuffer_reg <= 8'h00;
      control_reg <= 8'h00;
      deadBand_reg <= 7'h00;
      prescSel_reg <= 2'h0;
      readData_reg <= 8'h00;
    end
    else
    begin
      periodLimit_reg <= periodLimit_next;
      dutyBuffer_reg <= dutyBuffer_next;
      control_reg <= control_next;
      deadBand_reg <= deadBand_next;
      prescSel_reg <= prescSel_next;
      readData_reg <= readData_next;
    end
  end
  assign readData = readData_reg;
  // ==========================================
  // timebase: quarter counter, prescaler, timer
  // postscaler lives outside; nothing here feeds it back RULE3
  logic [1:0] qtr_reg, qtr_next;
  logic [3:0] presc_reg, presc_next;
  logic [3:0] prescMax;
  logic tick, periodEnd, lastCount;
  always_comb
  begin
    case (prescSel_reg) // RULE16
      2'h0: prescMax = 4'h0;
      2'h1: prescMax = 4'h3;
      default: prescMax = 4'hf;
    endcase
    tick = (qtr_reg == QTR_LAST) && (presc_reg >= prescMax);
    periodEnd = tick && (timer_reg == periodLimit_reg); // RULE1
    // the final count lasts 4*prescale clocks: the direction swap window
    lastCount = (timer_reg == periodLimit_reg);
    qtr_next = qtr_reg + 2'h1;
    presc_next = presc_reg;
    timer_next = timer_reg;
    if (qtr_reg == QTR_LAST)
      presc_next = tick ? 4'h0 : presc_reg + 4'h1;
    if (tick)
      timer_next = periodEnd ? 8'h00 : timer_reg + 8'h01; // RULE2
    // prescaler restarts on a rate change so it never sits past its limit
    if (bus.wr && bus.addr == ADDR_TIMER_CONTROL)
      presc_next = 4'h0; // RULE16
  end
  // ==========================================
  // duty, shadow controls and output shaping
  logic [1:0] mode_reg, mode_next;
  logic dir_reg, dir_next;
  logic [1:0] pol_reg, pol_next;
  logic [6:0] dbActive_reg, dbActive_next;
  logic pwm_reg, pwm_next;
  logic [6:0] dbA_reg, dbA_next, dbB_reg, dbB_next;
  ebp_out_t out_reg, out_next;
  logic [9:0] extTimer;
  logic [9:0] newDuty;
  logic swapWin;
  logic aRaw, bRaw;
  always_comb
  begin
    newDuty = {dutyBuffer_reg, control_reg[DUTY_LSB_HI:DUTY_LSB_LO]}; // RULE4
    // next count compared, so the pin falls after exactly duty steps
    // low bits: quarter clock at 1:1, prescaler bits otherwise RULE7
    case (prescSel_reg)
      2'h0: extTimer = {timer_next, qtr_next};
      2'h1: extTimer = {timer_next, presc_next[1:0]};
      default: extTimer = {timer_next, presc_next[3:2]};
    endcase
    dutyActive_next = dutyActive_reg;
    mode_next = mode_reg;
    dir_next = dir_reg;
    pol_next = pol_reg;
    dbActive_next = dbActive_reg;
    pwm_next = pwm_reg;
    if (periodEnd)
    begin
      dutyActive_next = newDuty; // RULE5
      mode_next = control_reg[MODE_HI:MODE_LO]; // RULE20
      dir_next = control_reg[DIR_BIT]; // RULE14
      pol_next = {control_reg[POL_BD_BIT], control_reg[POL_AC_BIT]}; // RULE21
      dbActive_next = deadBand_reg; // RULE20
      pwm_next = (newDuty != 10'h000); // RULE2
    end
    // never matches when duty exceeds period RULE8
    else if (extTimer == dutyActive_reg)
    begin
      pwm_next = 1'b0; // RULE7
      dbActive_next = deadBand_reg; // RULE20
    end
    // dead band counters, one per half-bridge leg
    dbA_next = dbA_reg;
    dbB_next = dbB_reg;
    if (!pwm_reg)
      dbA_next = 7'h00;
    else if (qtr_reg == QTR_LAST && dbA_reg != 7'h7f)
      dbA_next = dbA_reg + 7'h01; // RULE11
    if (pwm_reg)
      dbB_next = 7'h00;
    else if (qtr_reg == QTR_LAST && dbB_reg != 7'h7f)
      dbB_next = dbB_reg + 7'h01; // RULE11
    // a leg still counting when pwm falls stays inactive RULE12
    aRaw = pwm_reg && (dbA_reg >= dbActive_reg);
    bRaw = !pwm_reg && (dbB_reg >= dbActive_reg);
    swapWin = (control_reg[DIR_BIT] != dir_reg) && lastCount; // RULE15
    out_next = '0;
    case (ebp_mode_t'(mode_reg)) // RULE9
      MODE_SINGLE: out_next.a = pwm_reg;
      MODE_HALF:
      begin
        out_next.a = aRaw; // RULE10
        out_next.b = bRaw; // RULE10
      end
      MODE_FWD:
      begin
        out_next.a = !swapWin; // RULE13 RULE17
        out_next.c = swapWin; // RULE15
        out_next.d = pwm_reg && !swapWin; // RULE13
      end
      MODE_REV:
      begin
        out_next.c = !swapWin; // RULE13 RULE17
        out_next.a = swapWin; // RULE15
        out_next.b = pwm_reg && !swapWin; // RULE13
      end
      default: out_next = '0;
    endcase
    // pin drive enables live in the port logic outside this block
    out_next.a = out_next.a ^ pol_reg[0]; // RULE21
    out_next.c = out_next.c ^ pol_reg[0];
    out_next.b = out_next.b ^ pol_reg[1];
    out_next.d = out_next.d ^ pol_reg[1];
  end
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      qtr_reg <= 2'h0;
      presc_reg <= 4'h0;
      timer_reg <= 8'h00;
      dutyActive_reg <= 10'h000;
      mode_reg <= 2'h0;
      dir_reg <= 1'b0;
      pol_reg <= 2'h0;
      dbActive_reg <= 7'h00;
      pwm_reg <= 1'b0;
      dbA_reg <= 7'h00;
      dbB_reg <= 7'h00;
      out_reg <= '0;
    end
    else
    begin
      qtr_reg <= qtr_next;
      presc_reg <= presc_next;
      timer_reg <= timer_next;
      dutyActive_reg <= dutyActive_next;
      mode_reg <= mode_next;
      dir_reg <= dir_next;
      pol_reg <= pol_next;
      dbActive_reg <= dbActive_next;
      pwm_reg <= pwm_next;
      dbA_reg <= dbA_next;
      dbB_reg <= dbB_next;
      out_reg <= out_next;
    end
  end
  assign pwmOut = out_reg;
  // ==========================================
  // assertions
  // pins lag the shaping by one edge, so compare with past polarity
  a_timer_wrap: assert property ( // RULE2
    @(posedge clock) disable iff (!reset_n)
    periodEnd |=> timer_reg == 8'h00)
    else $error("timer did not clear at period end");
  a_duty_load: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    periodEnd |=> dutyActive_reg == $past(newDuty))
    else $error("duty copy not loaded at period end");
  a_duty_hold: assert property ( // RULE6
    @(posedge clock) disable iff (!reset_n)
    !periodEnd |=> $stable(dutyActive_reg))
    else $error("duty copy changed mid period");
  a_pwm_set: assert property ( // RULE2
    @(posedge clock) disable iff (!reset_n)
    periodEnd && newDuty != 10'h000 |=> pwm_reg)
    else $error("pwm not set at period start");
  a_pwm_clear: assert property ( // RULE7
    @(posedge clock) disable iff (!reset_n)
    !periodEnd && extTimer == dutyActive_reg |=> !pwm_reg)
    else $error("pwm not cleared on duty match");
  a_presc_range: assert property ( // RULE16
    @(posedge clock) disable iff (!reset_n)
    presc_reg <= prescMax)
    else $error("prescaler beyond its limit");
  a_dir_hold: assert property ( // RULE14
    @(posedge clock) disable iff (!reset_n)
    !periodEnd |=> $stable(dir_reg))
    else $error("direction changed mid period");
  a_db_half: assert property ( // RULE11
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_HALF && $rose(pwm_reg) && dbActive_reg != 7'h00
    |=> (out_reg.a ^ $past(pol_reg[0])) == 1'b0)
    else $error("half-bridge rose without dead band");
  a_fwd_hold: assert property ( // RULE13
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_FWD |=> out_reg.b == $past(pol_reg[1]))
    else $error("output b active in forward mode");
  a_rev_hold: assert property ( // RULE13
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_REV |=> out_reg.d == $past(pol_reg[1]))
    else $error("output d active in reverse mode");
  a_single_only: assert property ( // RULE9
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_SINGLE |=> out_reg.c == $past(pol_reg[0]))
    else $error("output c active in single mode");
  a_half_apart: assert property ( // RULE10
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_HALF |=> !((out_reg.a ^ $past(pol_reg[0]))
    && (out_reg.b ^ $past(pol_reg[1]))))
    else $error("both half-bridge legs active");
  a_fwd_swap: assert property ( // RULE15
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_FWD && swapWin |=> out_reg.d == $past(pol_reg[1]))
    else $error("output d active in swap window");
  a_rev_swap: assert property ( // RULE15
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_REV && swapWin |=> out_reg.b == $past(pol_reg[1]))
    else $error("output b active in swap window");
  a_full_nodb: assert property ( // RULE17
    @(posedge clock) disable iff (!reset_n)
    mode_reg == MODE_FWD && $rose(pwm_reg) && !swapWin
    |=> out_reg.d != $past(pol_reg[1]))
    else $error("full-bridge output delayed");
endmodule : ebp_pwm

/* rtl/ebp_pkg.sv */
package ebp_pkg;
  // register index map
  localparam logic [2:0] ADDR_PERIOD_LIMIT = 3'h0;
  localparam logic [2:0] ADDR_DUTY_BUFFER = 3'h1;
  localparam logic [2:0] ADDR_DUTY_ACTIVE = 3'h2;
  localparam logic [2:0] ADDR_PWM_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_DEAD_BAND = 3'h4;
  localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h5;
  localparam logic [2:0] ADDR_TIMER_VALUE = 3'h6;
  // pwm_control fields, and the top bit of the dead band register
  localparam int DIR_BIT = 7;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int DUTY_LSB_HI = 5;
  localparam int DUTY_LSB_LO = 4;
  localparam int POL_AC_BIT = 0;
  localparam int POL_BD_BIT = 1;
  localparam int DB_HI = 6;
  // instruction cycle in oscillator periods
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] QTR_LAST = 2'h3;
  typedef enum logic [1:0]
  {
    MODE_SINGLE = 2'b00,
    MODE_HALF = 2'b10,
    MODE_FWD = 2'b01,
    MODE_REV = 2'b11
  } ebp_mode_t;
  typedef struct packed
  {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ebp_bus_t;
  typedef struct packed
  {
    logic a;
    logic b;
    logic c;
    logic d;
  } ebp_out_t;
endpackage : ebp_pkg

/* bench/ebp_bridge_model.sv */
`timescale 1ns/1ps
// ==========================================================
// bridge switch drivers seen from the pins
module ebp_bridge_model
  import ebp_pkg::*;
(
  // clock
  input wire logic clock,
  // pins and their drive enable
  input wire ebp_out_t pwmOut,
  input wire logic driveEn,
  // shoot-through events
  output logic [31:0] overlapCount
);
  initial overlapCount = 32'h0;
  // pins only switch the bridge once enabled
  // both switches of one leg on is shoot-through
  always @(posedge clock)
  begin
    if (driveEn && ((pwmOut.a && pwmOut.b) || (pwmOut.c && pwmOut.d)))
      overlapCount <= overlapCount + 32'h1;
  end
endmodule : ebp_bridge_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import ebp_pkg::*;
  ;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ebp_bus_t bus = '0;
  logic [7:0] readData;
  ebp_out_t pwmOut;
  logic driveEn = 1'b0;
  logic [31:0] overlapCount;
  logic [7:0] rdv;
  int miscompares = 0;
  int comparisons = 0;
  int swapRun = 0;

  ebp_pwm u_dut (.clock(clock), .reset_n(reset_n), .bus(bus),
    .readData(readData), .pwmOut(pwmOut));
  ebp_bridge_model u_bridge (.clock(clock), .pwmOut(pwmOut),
    .driveEn(driveEn), .overlapCount(overlapCount));

  initial forever #25 clock = ~clock;

  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = readData;
  endtask : rd

  // window is a whole number of periods, so phase does not matter
  task run(input logic [7:0] ctrl, input logic [7:0] db,
    input logic [7:0] pre, input logic [7:0] duty, input int n,
    input int ea, input int eb, input int ec, input int ed,
    input int er);
    int ca, cb, cc, cd, rises;
    logic prevA;
    ca = 0; cb = 0; cc = 0; cd = 0; rises = 0; prevA = 1'b1;
    wr(ADDR_PWM_CONTROL, ctrl);
    wr(ADDR_DEAD_BAND, db);
    wr(ADDR_TIMER_CONTROL, pre);
    wr(ADDR_DUTY_BUFFER, duty);
    repeat (600) @(posedge clock);
    #1 prevA = pwmOut.a;
    repeat (n)
    begin
      @(posedge clock);
      #1;
      ca += pwmOut.a; cb += pwmOut.b; cc += pwmOut.c; cd += pwmOut.d;
      if (pwmOut.a && !prevA) rises++;
      prevA = pwmOut.a;
    end
    check(ca, ea);
    check(cb, eb);
    check(cc, ec);
    check(cd, ed);
    check(rises, er);
    $display("test ctrl %h duty %h done", ctrl, duty);
  endtask : run

  task tally_and_finish;
    $display("compares %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // sequence: limit 3 gives a 16-clock period at prescale 1
  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd(ADDR_PERIOD_LIMIT, rdv);
    check(rdv, 8'hff);
    @(posedge clock);
    #1 check(readData, 8'h00);
    rd(3'h7, rdv);
    check(rdv, 8'h00);
    $display("test reset done");
    wr(ADDR_PERIOD_LIMIT, 8'h03);
    run(8'h00, 8'h00, 8'h00, 8'h02, 64, 32, 0, 0, 0, 4);
    rd(ADDR_DUTY_ACTIVE, rdv);
    check(rdv, 8'h02);
    wr(ADDR_DUTY_ACTIVE, 8'h55);
    rd(ADDR_DUTY_ACTIVE, rdv);
    check(rdv, 8'h02);
    run(8'h10, 8'h00, 8'h00, 8'h02, 64, 36, 0, 0, 0, 4);
    run(8'h00, 8'h00, 8'h00, 8'h00, 64, 0, 0, 0, 0, 0);
    run(8'h00, 8'h00, 8'h00, 8'hff, 64, 64, 0, 0, 0, 0);
    run(8'h00, 8'h00, 8'h01, 8'h02, 128, 64, 0, 0, 0, 2);
    run(8'h00, 8'h00, 8'h02, 8'h02, 256, 128, 0, 0, 0, 1);
    run(8'h43, 8'h00, 8'h00, 8'h02, 64, 0, 64, 64, 32, 0);
    // pins enabled only after whole cycles in a known mode
    wr(ADDR_PWM_CONTROL, 8'h80);
    repeat (40) @(posedge clock);
    driveEn <= 1'b1;
    run(8'h80, 8'h01, 8'h00, 8'h02, 64, 16, 16, 0, 0, 4);
    run(8'h80, 8'h03, 8'h00, 8'h02, 64, 0, 0, 0, 0, 0);
    run(8'h40, 8'h01, 8'h00, 8'h02, 64, 64, 0, 0, 32, 0);
    run(8'hc0, 8'h01, 8'h00, 8'h02, 64, 0, 32, 64, 0, 0);
    // flip direction early in a period, then time the swap window
    repeat (40)
    begin
      @(posedge clock);
      #1;
      if (pwmOut.b)
        break;
    end
    check(pwmOut.b, 1'b1);
    wr(ADDR_PWM_CONTROL, 8'h40);
    repeat (100)
    begin
      @(posedge clock);
      #1;
      if (pwmOut.d)
        break;
      swapRun = (pwmOut.a && !pwmOut.b && !pwmOut.c) ? swapRun + 1 : 0;
    end
    check(pwmOut.d, 1'b1);
    check(swapRun, OSC_PER_CYCLE);
    $display("test direction swap done");
    run(8'h40, 8'h00, 8'h00, 8'h02, 64, 64, 0, 0, 32, 0);
    check(overlapCount, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
